// [pkg/compare_waveform_map.vh]
// register offsets, fields, reset values and codes for the compare waveform block
`ifndef COMPARE_WAVEFORM_MAP_VH
`define COMPARE_WAVEFORM_MAP_VH
`define CW_ADDR_CTRL      8'h00
`define CW_ADDR_WAVE      8'h04
`define CW_ADDR_DRV       8'h08
`define CW_ADDR_INTEN     8'h0C
`define CW_ADDR_EVEN      8'h10
`define CW_ADDR_FLAG      8'h14
`define CW_ADDR_CMD       8'h18
`define CW_ADDR_PERIOD    8'h1C
`define CW_ADDR_PERBUF    8'h20
`define CW_ADDR_COUNT     8'h24
`define CW_ADDR_CAPMODE   8'h28
`define CW_ADDR_CC_BASE   8'h40
`define CW_ADDR_CCB_BASE  8'h80
`define CW_CTRL_EN_BIT    0
`define CW_CMD_NONE       2'h0
`define CW_CMD_UPDATE     2'h3
`define CW_WAVE_NORMAL_FREQUENCY_MODE      3'h0
`define CW_WAVE_MATCH_FREQUENCY_MODE      3'h1
`define CW_WAVE_SINGLE_SLOPE_PWM_MODE      3'h2
`define CW_WAVE_DUAL_SLOPE_TOP_MODE     3'h4
`define CW_WAVE_DSZERO    3'h5
`define CW_WAVE_DUAL_SLOPE_BOTH_MODE    3'h6
`define CW_WAVE_DSCRIT    3'h7
`define CW_RST_WAVE       3'h0
`define CW_RST_CAPMODE    1'b0
`define CW_RST_PERIOD     16'hFFFF
`endif

// [rtl/compare_waveform_channels.v]
// compare, double buffering and waveform generation for a timer's channels
// What this block does
// R1: channels reset into compare mode
// R2: counter compared with every active compare value
// R3: active value loads from buffer on update
// R4: buffered loads happen only at update point
// R5: mode selects waveform; invert bit flips output
// R6: match flag set on next counting clock
// R7: match gives interrupt and event when enabled
// R8: every match also raises a DMA request
// R9: seven waveform modes supported
// R10: dual-slope modes choose top/zero/both/critical events
// R11: match-frequency top is channel zero compare
// R12: other modes take top from period
// R13: dual-slope updates when counter reaches zero
// R14: other modes update on wrap or retrigger
// R15: single-slope output set at zero, cleared on match
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "compare_waveform_map.vh"
module compare_waveform_channels #(
  parameter integer CH = 4,
  parameter integer CW = 16
) (
  input  wire          clk_i,
  input  wire          nrst_i,
  input  wire [7:0]    addr_i,
  input  wire [31:0]   wdata_i,
  input  wire          wr_i,
  input  wire          rd_i,
  input  wire          count_en_i,
  input  wire          retrigger_i,
  output reg  [31:0]   rdata_o,
  output reg  [CH-1:0] channel_waveform_output_o,
  output reg           irq_o,
  output reg  [CH-1:0] match_event_o,
  output reg  [CH-1:0] dma_req_o,
  output reg           ovf_event_o,
  output reg           critical_o
);

  reg            enable_q;
  reg  [2:0]     waveform_mode_field_q;
  reg  [CH-1:0]  output_invert_bit_q;
  reg  [CH-1:0]  channel_match_irq_enable_q;
  reg  [CH-1:0]  channel_match_event_enable_q;
  reg  [CH-1:0]  channel_match_flag_q;
  reg  [CH-1:0]  capture_mode_q;
  reg  [CW-1:0]  period_register_q;
  reg  [CW-1:0]  period_buf_q;
  reg  [CW-1:0]  count_q;
  reg            down_q;
  reg            force_upd_q;
  reg  [CW-1:0]  channel_compare_value_q  [0:CH-1];
  reg  [CW-1:0]  channel_compare_buffer_q [0:CH-1];
  reg  [CH-1:0]  wave_q;

  wire           dual_slope;
  wire           match_frequency_mode;
  wire [CW-1:0]  top;
  wire           tick;
  wire           at_top;
  wire           at_zero;
  wire           wrap;
  wire           ds_zero;
  wire           ds_top;
  wire           cmd_wr;
  wire           force_cmd;
  wire           update;
  reg            ovf_ev;
  reg            crit_ev;
  wire [CH-1:0]  match;

  // top source, ticks and update point
  assign dual_slope = waveform_mode_field_q[2];
  assign match_frequency_mode       = (waveform_mode_field_q == `CW_WAVE_MATCH_FREQUENCY_MODE);
  assign top        = match_frequency_mode ? channel_compare_value_q[0] : period_register_q; // [R11] [R12]
  assign tick       = enable_q & count_en_i;
  assign at_top     = (count_q == top);
  assign at_zero    = (count_q == {CW{1'b0}});
  assign wrap       = tick & ~dual_slope & at_top;
  assign ds_zero    = tick & dual_slope & down_q & (count_q == {{(CW-1){1'b0}}, 1'b1});
  assign ds_top     = tick & dual_slope & ~down_q & at_top;
  assign cmd_wr     = wr_i & (addr_i == `CW_ADDR_CMD);
  assign force_cmd  = cmd_wr & (wdata_i[1:0] == `CW_CMD_UPDATE);
  assign update     = ds_zero | wrap | (enable_q & retrigger_i) | force_upd_q; // [R13] [R14]

  // dual-slope and single-slope event selection
  always @* begin
    ovf_ev  = 1'b0;
    crit_ev = 1'b0;
    case (waveform_mode_field_q)
      `CW_WAVE_NORMAL_FREQUENCY_MODE: begin
        ovf_ev = wrap;
      end
      `CW_WAVE_MATCH_FREQUENCY_MODE: begin
        ovf_ev = wrap;
      end
      `CW_WAVE_SINGLE_SLOPE_PWM_MODE: begin
        ovf_ev = wrap;
      end
      `CW_WAVE_DUAL_SLOPE_TOP_MODE: begin
        ovf_ev = ds_top; // [R10]
      end
      `CW_WAVE_DSZERO: begin
        ovf_ev = ds_zero; // [R10]
      end
      `CW_WAVE_DUAL_SLOPE_BOTH_MODE: begin
        ovf_ev = ds_top | ds_zero; // [R10]
      end
      `CW_WAVE_DSCRIT: begin
        crit_ev = ds_zero; // [R10]
      end
      default: begin
        ovf_ev = 1'b0;
      end
    endcase
  end

  // counter
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_q <= {CW{1'b0}};
      down_q  <= 1'b0;
    end else if (enable_q & retrigger_i) begin
      count_q <= {CW{1'b0}};
      down_q  <= 1'b0;
    end else if (tick) begin
      if (!dual_slope) begin
        count_q <= at_top ? {CW{1'b0}} : count_q + 1'b1;
        down_q  <= 1'b0;
      end else if (!down_q) begin
        if (at_top) begin
          count_q <= count_q - 1'b1;
          down_q  <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end else begin
        if (count_q <= {{(CW-1){1'b0}}, 1'b1}) begin
          count_q <= {CW{1'b0}};
          down_q  <= 1'b0;
        end else begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

  // per-channel compare, buffer and waveform
  genvar g;
  generate
    for (g = 0; g < CH; g = g + 1) begin : chan
      wire [31:0] cc_sum   = `CW_ADDR_CC_BASE + g * 4;
      wire [31:0] ccb_sum  = `CW_ADDR_CCB_BASE + g * 4;
      wire [7:0]  cc_addr  = cc_sum[7:0];
      wire [7:0]  ccb_addr = ccb_sum[7:0];
      assign match[g] = tick & ~capture_mode_q[g] &
                        (count_q == channel_compare_value_q[g]); // [R2]
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          channel_compare_value_q[g]  <= {CW{1'b0}};
          channel_compare_buffer_q[g] <= {CW{1'b0}};
        end else begin
          if (wr_i && addr_i == ccb_addr)
            channel_compare_buffer_q[g] <= wdata_i[CW-1:0];
          if (update)
            channel_compare_value_q[g] <= channel_compare_buffer_q[g]; // [R3] [R4]
          else if (wr_i && addr_i == cc_addr)
            channel_compare_value_q[g] <= wdata_i[CW-1:0];
        end
      end
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          wave_q[g] <= 1'b0;
        end else if (tick) begin
          case (waveform_mode_field_q)
            `CW_WAVE_NORMAL_FREQUENCY_MODE: begin
              if (wrap) wave_q[g] <= ~wave_q[g];
            end
            `CW_WAVE_MATCH_FREQUENCY_MODE: begin
              if (wrap) wave_q[g] <= ~wave_q[g];
            end
            `CW_WAVE_SINGLE_SLOPE_PWM_MODE: begin
              if (match[g]) wave_q[g] <= 1'b0; // [R15]
              else if (at_zero) wave_q[g] <= 1'b1; // [R15]
            end
            default: begin
              if (count_q < channel_compare_value_q[g]) wave_q[g] <= 1'b0;
              else wave_q[g] <= 1'b1;
            end
          endcase
        end
      end
    end
  endgenerate

  // software registers
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_q                     <= 1'b0;
      waveform_mode_field_q        <= `CW_RST_WAVE;
      output_invert_bit_q          <= {CH{1'b0}};
      channel_match_irq_enable_q   <= {CH{1'b0}};
      channel_match_event_enable_q <= {CH{1'b0}};
      capture_mode_q               <= {CH{`CW_RST_CAPMODE}}; // [R1]
      period_register_q            <= `CW_RST_PERIOD;
      period_buf_q                 <= `CW_RST_PERIOD;
      force_upd_q                  <= 1'b0;
    end else begin
      force_upd_q <= force_cmd; // [R3]
      if (update)
        period_register_q <= period_buf_q; // [R4]
      if (wr_i) begin
        case (addr_i)
          `CW_ADDR_CTRL: begin
            enable_q <= wdata_i[`CW_CTRL_EN_BIT];
          end
          `CW_ADDR_WAVE: begin
            waveform_mode_field_q <= wdata_i[2:0]; // [R9]
          end
          `CW_ADDR_DRV: begin
            output_invert_bit_q <= wdata_i[CH-1:0];
          end
          `CW_ADDR_INTEN: begin
            channel_match_irq_enable_q <= wdata_i[CH-1:0];
          end
          `CW_ADDR_EVEN: begin
            channel_match_event_enable_q <= wdata_i[CH-1:0];
          end
          `CW_ADDR_CAPMODE: begin
            capture_mode_q <= wdata_i[CH-1:0];
          end
          `CW_ADDR_PERBUF: begin
            period_buf_q <= wdata_i[CW-1:0];
          end
          default: begin
            enable_q <= enable_q;
          end
        endcase
      end
    end
  end

  // match flags: set wins over write-one-to-clear
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      channel_match_flag_q <= {CH{1'b0}};
    end else if (wr_i && addr_i == `CW_ADDR_FLAG) begin
      channel_match_flag_q <= (channel_match_flag_q & ~wdata_i[CH-1:0]) | match; // [R6]
    end else begin
      channel_match_flag_q <= channel_match_flag_q | match; // [R6]
    end
  end

  // outputs, all registered
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      channel_waveform_output_o <= {CH{1'b0}};
      irq_o                     <= 1'b0;
      match_event_o             <= {CH{1'b0}};
      dma_req_o                 <= {CH{1'b0}};
      ovf_event_o               <= 1'b0;
      critical_o                <= 1'b0;
    end else begin
      channel_waveform_output_o <= wave_q ^ output_invert_bit_q; // [R5]
      irq_o         <= |(channel_match_flag_q & channel_match_irq_enable_q); // [R7]
      match_event_o <= match & channel_match_event_enable_q; // [R7]
      dma_req_o     <= match; // [R8]
      ovf_event_o   <= ovf_ev;
      critical_o    <= crit_ev;
    end
  end

  // read data, one cycle after the strobe
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= 32'h0000_0000;
      case (addr_i)
        `CW_ADDR_CTRL: begin
          rdata_o[0] <= enable_q;
        end
        `CW_ADDR_WAVE: begin
          rdata_o[2:0] <= waveform_mode_field_q;
        end
        `CW_ADDR_DRV: begin
          rdata_o[CH-1:0] <= output_invert_bit_q;
        end
        `CW_ADDR_INTEN: begin
          rdata_o[CH-1:0] <= channel_match_irq_enable_q;
        end
        `CW_ADDR_EVEN: begin
          rdata_o[CH-1:0] <= channel_match_event_enable_q;
        end
        `CW_ADDR_FLAG: begin
          rdata_o[CH-1:0] <= channel_match_flag_q;
        end
        `CW_ADDR_PERIOD: begin
          rdata_o[CW-1:0] <= period_register_q;
        end
        `CW_ADDR_PERBUF: begin
          rdata_o[CW-1:0] <= period_buf_q;
        end
        `CW_ADDR_COUNT: begin
          rdata_o[CW-1:0] <= count_q;
        end
        `CW_ADDR_CAPMODE: begin
          rdata_o[CH-1:0] <= capture_mode_q;
        end
        default: begin
          rdata_o <= rd_mux(addr_i);
        end
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // compare and buffer read-back
  function [31:0] rd_mux;
    input [7:0] a;
    integer i;
    begin
      rd_mux = 32'h0000_0000;
      for (i = 0; i < CH; i = i + 1) begin
        if (a == `CW_ADDR_CC_BASE + i * 4)
          rd_mux[CW-1:0] = channel_compare_value_q[i];
        if (a == `CW_ADDR_CCB_BASE + i * 4)
          rd_mux[CW-1:0] = channel_compare_buffer_q[i];
      end
    end
  endfunction

endmodule
`default_nettype wire

// [tb/compare_waveform_channels_bench.sv]
// self-checking bench for the compare waveform block
`timescale 1ns/1ps
`default_nettype none
`include "compare_waveform_map.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module compare_waveform_channels_bench;
  localparam integer CH = 4;
  localparam integer P = 20;
  logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, count_en_i = 0, retrigger_i = 0, clr = 0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, rv, lf = 32'h463D1D31;
  logic [CH-1:0] wave, mev, dma;
  logic irq_o, ovf, crit;
  logic [15:0] hc [CH];
  logic [7:0] dc [CH], ec [CH];
  logic [2:0] md [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  int err_count = 0, n_compared = 0, cc [CH], inv, evm, g;
  always #2 clk_i = ~clk_i;
  compare_waveform_channels #(.CH(CH), .CW(16)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .count_en_i(count_en_i),
    .retrigger_i(retrigger_i), .rdata_o(rdata_o), .channel_waveform_output_o(wave),
    .irq_o(irq_o), .match_event_o(mev), .dma_req_o(dma), .ovf_event_o(ovf), .critical_o(crit));
  pin_load_model #(.CH(CH)) pins (.clk_i(clk_i), .clr_i(clr), .pins_i(wave), .high_cnt_o(hc));
  always @(posedge clk_i)
    for (int i = 0; i < CH; i++) begin
      dc[i] <= clr ? 8'h0 : dc[i] + 8'(dma[i]);
      ec[i] <= clr ? 8'h0 : ec[i] + 8'(mev[i]);
    end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int gap_of(input logic [2:0] m);
    case (m)
      3'h0, 3'h2: return P + 1;
      3'h1: return cc[0] + 1;
      3'h6: return P - 1;
      default: return 2 * P;
    endcase
  endfunction
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i); wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i); rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clk_i);
  endtask
  task automatic pulse_gap(input bit c, output int n);
    int t;
    #1;
    for (t = 0; t < 200 && !(c ? crit : ovf); t++) @(posedge clk_i) #1;
    for (n = 1; n < 200; n++) begin @(posedge clk_i) #1; if (c ? crit : ovf) break; end
    if (t == 200 || n == 200) begin err_count++; complete_run; end
    @(posedge clk_i);
  endtask
  initial begin #200000; err_count++; complete_run; end
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(`CW_ADDR_WAVE, rv); `CHK("wave", 32'h0, rv)
    rd(`CW_ADDR_CAPMODE, rv); `CHK("capmode", 32'h0, rv)
    rd(`CW_ADDR_PERIOD, rv); `CHK("period", 32'hFFFF, rv)
    rd(8'hFC, rv); `CHK("unmapped", 32'h0, rv)
    $display("reset test done");
    wr(`CW_ADDR_PERBUF, P);
    for (int k = 0; k < CH; k++) begin
      lf = nx(lf); cc[k] = lf % P + 1;
      wr(`CW_ADDR_CCB_BASE + 8'(4 * k), cc[k]);
      rd(`CW_ADDR_CC_BASE + 8'(4 * k), rv); `CHK("cc held", 32'h0, rv)
    end
    wr(`CW_ADDR_CMD, `CW_CMD_UPDATE);
    rd(`CW_ADDR_PERIOD, rv); `CHK("period upd", P, rv)
    for (int k = 0; k < CH; k++) begin
      rd(`CW_ADDR_CC_BASE + 8'(4 * k), rv); `CHK("cc upd", cc[k], rv)
    end
    $display("buffer test done");
    lf = nx(lf); inv = lf[3:0]; evm = lf[7:4];
    wr(`CW_ADDR_DRV, inv); wr(`CW_ADDR_EVEN, evm); wr(`CW_ADDR_WAVE, `CW_WAVE_SINGLE_SLOPE_PWM_MODE);
    count_en_i <= 1'b1;
    wr(`CW_ADDR_CTRL, 32'h1);
    repeat (2 * P) @(posedge clk_i);
    clr <= 1'b1; @(posedge clk_i); clr <= 1'b0;
    repeat (P + 1) @(posedge clk_i);
    #1;
    for (int k = 0; k < CH; k++) begin
      `CHK("duty", inv[k] ? P + 1 - cc[k] : cc[k], hc[k])
      `CHK("dma", 8'h1, dc[k])
      `CHK("event", 8'(evm[k]), ec[k])
    end
    @(posedge clk_i);
    count_en_i <= 1'b0;
    rd(`CW_ADDR_FLAG, rv); `CHK("flags", 32'hF, rv)
    wr(`CW_ADDR_INTEN, 32'h0); @(posedge clk_i); `CHK("irq masked", 1'b0, irq_o)
    wr(`CW_ADDR_INTEN, 32'h1); @(posedge clk_i); `CHK("irq set", 1'b1, irq_o)
    wr(`CW_ADDR_FLAG, 32'hF); @(posedge clk_i); `CHK("irq clr", 1'b0, irq_o)
    $display("match test done");
    count_en_i <= 1'b1;
    foreach (md[i]) begin
      wr(`CW_ADDR_WAVE, md[i]);
      retrigger_i <= 1'b1; @(posedge clk_i); retrigger_i <= 1'b0; @(posedge clk_i);
      pulse_gap(md[i] == `CW_WAVE_DSCRIT, g);
      `CHK("top gap", gap_of(md[i]), g)
    end
    $display("mode test done");
    complete_run;
  end
endmodule
`default_nettype wire

// [tb/compare_waveform_channels_monitor.sv]
// assertion checker for the compare waveform block
`timescale 1ns/1ps
`default_nettype none
module compare_waveform_channels_monitor #(
  parameter integer CH = 4
) (
  input wire logic          clk_i,
  input wire logic          nrst_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic          count_en_i,
  input wire logic          retrigger_i,
  input wire logic [31:0]   rdata_o,
  input wire logic [CH-1:0] channel_waveform_output_o,
  input wire logic          irq_o,
  input wire logic [CH-1:0] match_event_o,
  input wire logic [CH-1:0] dma_req_o,
  input wire logic          ovf_event_o,
  input wire logic          critical_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_evt_dma; (match_event_o & ~dma_req_o) == '0; endproperty
  a_evt_dma: assert property (p_evt_dma) else $error("event without match");
  property p_dma_tick; |dma_req_o |-> $past(count_en_i) || $past(count_en_i, 2); endproperty
  a_dma_tick: assert property (p_dma_tick) else $error("dma without count");
  property p_irq_rise;
    $rose(irq_o) |-> $past(|dma_req_o) || $past(|dma_req_o, 2) || $past(wr_i) || $past(wr_i, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
  property p_irq_fall; $fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  property p_ovf_tick;
    ovf_event_o |-> $past(count_en_i) || $past(count_en_i, 2) || $past(retrigger_i, 2);
  endproperty
  a_ovf_tick: assert property (p_ovf_tick) else $error("overflow without count");
  property p_crit_tick; critical_o |-> $past(count_en_i) || $past(count_en_i, 2); endproperty
  a_crit_tick: assert property (p_crit_tick) else $error("critical without count");
  property p_wave_hold;
    $changed(channel_waveform_output_o) |-> $past(count_en_i) || $past(count_en_i, 2)
      || $past(wr_i, 2) || $past(wr_i, 3) || $past(retrigger_i, 2);
  endproperty
  a_wave_hold: assert property (p_wave_hold) else $error("waveform moved alone");
endmodule
bind compare_waveform_channels compare_waveform_channels_monitor #(.CH(CH)) mon (
  .clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .rd_i(rd_i), .count_en_i(count_en_i),
  .retrigger_i(retrigger_i), .rdata_o(rdata_o), .channel_waveform_output_o(channel_waveform_output_o),
  .irq_o(irq_o), .match_event_o(match_event_o), .dma_req_o(dma_req_o),
  .ovf_event_o(ovf_event_o), .critical_o(critical_o));
`default_nettype wire

// [tb/pin_load_model.sv]
// pin load model counting high cycles per waveform pin
`timescale 1ns/1ps
`default_nettype none
module pin_load_model #(
  parameter integer CH = 4
) (
  input  wire logic          clk_i,
  input  wire logic          clr_i,
  input  wire logic [CH-1:0] pins_i,
  output var  logic [15:0]   high_cnt_o [CH]
);
  always @(posedge clk_i)
    for (int i = 0; i < CH; i++)
      high_cnt_o[i] <= clr_i ? 16'h0 : high_cnt_o[i] + 16'(pins_i[i]);
endmodule
`default_nettype wire
